//--- logic/pcrc_gen.sv
// Programmable CRC generator with data FIFO behind an APB slave.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`include "pcrc_regs.svh"
// Behaviour
// - Direction bit zero MSb first, one LSb
// - Checksum stays normal in both directions
// - Select zero: event when count goes 1->0
// - Select one: event when hardware clears go
// - Software clearing go raises no event
// - Select zero: result final (width+1)/2 cycles after event
// - Hardware clears go on completion
// - Disable resets engine, FIFO, result, high data
// - Stop-in-idle halts shift engine in Idle
// - Five-bit valid word count readable
// - Width field bits 12-8, width minus one
// - Length field bits 4-0, length minus one
// - Low terms x15..x1, bit 0 reads zero
// - High terms x31..x16
// - Two bits shifted per clock
// - FIFO depth 4, 8 or 16 by width
// - Count rises on write of high data above 16 bits wide, else of low data
// - Shift only with go and words waiting
module pcrc_gen
	import pcrc_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire pcrc_apb_req_t apb_req,
	output pcrc_apb_rsp_t apb_rsp,
	// Device power state and event.
	input wire logic idle_mode,
	output logic crc_event
);
	pcrc_state_t st;
	pcrc_state_t next_st;
	logic acc;
	logic wr;
	logic halt;
	logic [4:0] depth;
	logic full;
	logic push;
	logic pop;
	logic fin;
	logic [31:0] word;
	logic [31:0] poly;
	logic [31:0] mask;
	logic [31:0] c;
	logic [5:0] r;
	logic [4:0] pos;
	logic fb;
	logic [31:0] rd;
	logic bad;

	assign apb_rsp = st.rsp;
	assign crc_event = st.irq;

	// ----------------------------------------
	// Next state.
	// ----------------------------------------
	always_comb
	begin
		next_st = st;
		next_st.irq = 1'b0;
		acc = apb_req.psel & apb_req.penable & st.rsp.pready;
		wr = acc & apb_req.pwrite;
		next_st.rsp.pready = apb_req.psel & apb_req.penable & ~st.rsp.pready;
		halt = st.sidl & idle_mode;
		if (st.dw > 5'd15)
			depth = `PCRC_DEPTH_WIDE;
		else if (st.dw >= 5'd8)
			depth = `PCRC_DEPTH_MID;
		else
			depth = `PCRC_DEPTH_NARROW;
		full = (st.valid_word_count == depth);
		poly = {st.xorh, st.xorl[15:1], 1'b1};
		mask = 32'hFFFFFFFF >> (5'd31 - st.pl);
		c = st.wdat;
		r = st.rem;
		pos = 5'h00;
		fb = 1'b0;
		pop = 1'b0;
		fin = 1'b0;
		// Serial engine.
		if (st.en && st.go && !halt)
		begin
			if (st.rem == 6'h00 && st.valid_word_count != 5'h00)
			begin
				pop = 1'b1;
				next_st.sbuf = st.fifo[st.rptr];
				next_st.rptr = 4'((st.rptr + 4'h1) & 4'(depth - 5'h01));
				next_st.valid_word_count = st.valid_word_count - 5'h01;
				next_st.rem = 6'({1'b0, st.dw} + 6'h01);
				next_st.ran = 1'b1;
			end
			else if (st.rem != 6'h00)
			begin
				for (int k = 0; k < `PCRC_BITS_PER_CLK; k++)
				begin
					if (r != 6'h00)
					begin
						pos = st.lsb ? 5'(st.dw - 5'(r - 6'h01)) : 5'(r - 6'h01);
						fb = c[st.pl] ^ st.sbuf[pos];
						c = (c << 1) & mask;
						if (fb)
							c = c ^ (poly & mask);
						r = r - 6'h01;
					end
				end
				next_st.wdat = c;
				next_st.rem = r;
			end
			else if (st.ran)
			begin
				fin = 1'b1;
				next_st.go = 1'b0;
				next_st.ran = 1'b0;
				if (st.isel)
					next_st.irq = 1'b1;
			end
		end
		// Register writes; a software set of go wins over the hardware clear.
		push = 1'b0;
		word = 32'h00000000;
		bad = 1'b0;
		if (wr)
		begin
			if (apb_req.paddr == `PCRC_OFS_CON1)
			begin
				next_st.en = apb_req.pwdata[`PCRC_BIT_EN];
				next_st.sidl = apb_req.pwdata[`PCRC_BIT_SIDL];
				next_st.isel = apb_req.pwdata[`PCRC_BIT_ISEL];
				next_st.go = apb_req.pwdata[`PCRC_BIT_GO];
				next_st.lsb = apb_req.pwdata[`PCRC_BIT_LSB];
			end
			else if (apb_req.paddr == `PCRC_OFS_CON2)
			begin
				next_st.dw = apb_req.pwdata[12:8];
				next_st.pl = apb_req.pwdata[4:0];
			end
			else if (apb_req.paddr == `PCRC_OFS_XORL)
				next_st.xorl = {apb_req.pwdata[15:1], 1'b0};
			else if (apb_req.paddr == `PCRC_OFS_XORH)
				next_st.xorh = apb_req.pwdata[15:0];
			else if (apb_req.paddr == `PCRC_OFS_DATL)
			begin
				next_st.datl = apb_req.pwdata[15:0];
				push = (st.dw < 5'd16) & ~full;
				word = {16'h0000, apb_req.pwdata[15:0]};
			end
			else if (apb_req.paddr == `PCRC_OFS_DATH)
			begin
				next_st.dath = apb_req.pwdata[15:0];
				push = (st.dw >= 5'd16) & ~full;
				word = {apb_req.pwdata[15:0], st.datl};
			end
			else if (apb_req.paddr == `PCRC_OFS_WDATL)
				next_st.wdat[15:0] = apb_req.pwdata[15:0];
			else if (apb_req.paddr == `PCRC_OFS_WDATH)
				next_st.wdat[31:16] = apb_req.pwdata[15:0];
		end
		if (push)
		begin
			next_st.fifo[st.wptr] = word;
			next_st.wptr = 4'((st.wptr + 4'h1) & 4'(depth - 5'h01));
			next_st.valid_word_count = next_st.valid_word_count + 5'h01;
		end
		// A refill in the cycle of the last pop keeps the count at one, so no event.
		if (pop && !push && st.valid_word_count == 5'h01 && !st.isel)
			next_st.irq = 1'b1;
		// Read data and error answer, latched when the access phase begins.
		if (apb_req.paddr == `PCRC_OFS_CON1)
			rd = {16'h0000, st.en, 1'b0, st.sidl, st.valid_word_count, full, (st.valid_word_count == 5'h00),
				st.isel, st.go, st.lsb, 3'b000};
		else if (apb_req.paddr == `PCRC_OFS_CON2)
			rd = {19'h00000, st.dw, 3'b000, st.pl};
		else if (apb_req.paddr == `PCRC_OFS_XORL)
			rd = {16'h0000, st.xorl[15:1], 1'b0};
		else if (apb_req.paddr == `PCRC_OFS_XORH)
			rd = {16'h0000, st.xorh};
		else if (apb_req.paddr == `PCRC_OFS_DATL)
			rd = {16'h0000, st.datl};
		else if (apb_req.paddr == `PCRC_OFS_DATH)
			rd = {16'h0000, st.dath};
		else if (apb_req.paddr == `PCRC_OFS_WDATL)
			rd = {16'h0000, st.wdat[15:0]};
		else if (apb_req.paddr == `PCRC_OFS_WDATH)
			rd = {16'h0000, st.wdat[31:16]};
		else
		begin
			rd = 32'h00000000;
			bad = 1'b1;
		end
		if (next_st.rsp.pready)
		begin
			next_st.rsp.prdata = apb_req.pwrite ? 32'h00000000 : rd;
			next_st.rsp.pslverr = bad;
		end
		else
		begin
			next_st.rsp.prdata = 32'h00000000;
			next_st.rsp.pslverr = 1'b0;
		end
		// Disabled module: engine, FIFO, result and high data are cleared.
		if (!st.en)
		begin
			next_st.wptr = 4'h0;
			next_st.rptr = 4'h0;
			next_st.valid_word_count = 5'h00;
			next_st.rem = 6'h00;
			next_st.ran = 1'b0;
			next_st.wdat = 32'h00000000;
			next_st.dath = `PCRC_RST16;
			next_st.irq = 1'b0;
		end
	end

	// ----------------------------------------
	// State register.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st <= '0;
		else
			st <= next_st;
	end

	// ----------------------------------------
	// Assertions.
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	empty_event_a: assert property (pop && !push && st.valid_word_count == 5'h01 && !st.isel |=> crc_event)
		else $error("Empty event missing.");
	refill_event_a: assert property (pop && push && st.valid_word_count == 5'h01 |=> !crc_event)
		else $error("Event although count stayed at one.");
	done_event_a: assert property (fin && st.isel && !wr |=> crc_event && !st.go)
		else $error("Completion event missing.");
	event_cause_a: assert property (crc_event |-> $past(pop || fin))
		else $error("Event without engine cause.");
	done_go_a: assert property (fin && !wr |=> !st.go)
		else $error("Go not cleared at completion.");
	disable_clear_a: assert property (!st.en |=> st.valid_word_count == 5'h00 && st.wdat == 32'h00000000
		&& st.dath == 16'h0000 && st.rem == 6'h00)
		else $error("Disable did not clear state.");
	idle_halt_a: assert property (st.en && halt |=> $stable(st.rem) && $stable(st.rptr))
		else $error("Engine moved while halted.");
	two_bits_a: assert property (st.en && st.go && !halt && st.rem >= 6'h02 |=> st.rem == $past(st.rem) - 6'h02)
		else $error("Shift rate wrong.");
	start_cond_a: assert property ($rose(st.ran) |-> $past(st.go) && $past(st.valid_word_count) != 5'h00)
		else $error("Shift began without go or data.");
	full_ignore_a: assert property (st.en && wr && full && !pop |=> st.valid_word_count == $past(st.valid_word_count))
		else $error("Write while full was taken.");
	width_field_a: assert property (wr && apb_req.paddr == `PCRC_OFS_CON2 |=> st.dw == $past(apb_req.pwdata[12:8]))
		else $error("Width field not stored.");
	count_limit_a: assert property (st.valid_word_count <= depth)
		else $error("Count above FIFO depth.");
	count_push_a: assert property (st.en && push && !pop |=> st.valid_word_count == $past(st.valid_word_count) + 5'h01)
		else $error("Count did not rise on push.");
	idle_run_a: assert property (st.en && st.go && !st.sidl && idle_mode && st.rem >= 6'h02
		|=> st.rem == $past(st.rem) - 6'h02)
		else $error("Engine stopped in idle without stop bit.");
	disable_keep_a: assert property (!st.en && !wr |=> $stable(st.xorl) && $stable(st.xorh)
		&& $stable(st.dw) && $stable(st.pl))
		else $error("Disable changed configuration.");

	// ----------------------------------------
	// Register field assertions.
	// ----------------------------------------
	go_set_a: assert property (wr && apb_req.paddr == `PCRC_OFS_CON1 && apb_req.pwdata[`PCRC_BIT_GO]
		|=> st.go)
		else $error("Go write not taken.");
	dir_store_a: assert property (wr && apb_req.paddr == `PCRC_OFS_CON1
		|=> st.lsb == $past(apb_req.pwdata[`PCRC_BIT_LSB]))
		else $error("Direction bit not stored.");
	length_field_a: assert property (wr && apb_req.paddr == `PCRC_OFS_CON2
		|=> st.pl == $past(apb_req.pwdata[4:0]))
		else $error("Length field not stored.");
	low_terms_a: assert property (wr && apb_req.paddr == `PCRC_OFS_XORL
		|=> st.xorl == {$past(apb_req.pwdata[15:1]), 1'b0})
		else $error("Low terms not stored.");
	high_terms_a: assert property (wr && apb_req.paddr == `PCRC_OFS_XORH
		|=> st.xorh == $past(apb_req.pwdata[15:0]))
		else $error("High terms not stored.");
	fifo_flags_a: assert property (apb_req.psel && apb_req.penable && !st.rsp.pready && !apb_req.pwrite
		&& apb_req.paddr == `PCRC_OFS_CON1
		|=> apb_rsp.prdata[7] == $past(full) && apb_rsp.prdata[6] == ($past(st.valid_word_count) == 5'h00))
		else $error("Full or empty flag misreported.");

	pop_c: cover property (pop);
	fin_c: cover property (fin && st.isel);
	full_c: cover property (st.en && full && wr);
	halt_c: cover property (st.go && halt);
	idle_run_c: cover property (st.go && idle_mode && !st.sidl && pop);
endmodule

//--- inc/pcrc_regs.svh
// Register offsets, field positions, reset values and counts of the CRC generator.
`ifndef PCRC_REGS_SVH
`define PCRC_REGS_SVH
// ----------------------------------------
// Register byte offsets.
// ----------------------------------------
`define PCRC_OFS_CON1 8'h00
`define PCRC_OFS_CON2 8'h04
`define PCRC_OFS_XORL 8'h08
`define PCRC_OFS_XORH 8'h0C
`define PCRC_OFS_DATL 8'h10
`define PCRC_OFS_DATH 8'h14
`define PCRC_OFS_WDATL 8'h18
`define PCRC_OFS_WDATH 8'h1C
// ----------------------------------------
// Field positions of the primary control register.
// ----------------------------------------
`define PCRC_BIT_EN 15
`define PCRC_BIT_SIDL 13
`define PCRC_BIT_ISEL 5
`define PCRC_BIT_GO 4
`define PCRC_BIT_LSB 3
// ----------------------------------------
// Reset values and counts.
// ----------------------------------------
`define PCRC_RST16 16'h0000
`define PCRC_DEPTH_WIDE 5'h04
`define PCRC_DEPTH_MID 5'h08
`define PCRC_DEPTH_NARROW 5'h10
`define PCRC_BITS_PER_CLK 2
`endif

//--- inc/pcrc_pkg.sv
// Types shared by the CRC generator.
package pcrc_pkg;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} pcrc_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} pcrc_apb_rsp_t;
	typedef struct packed {
		logic en;
		logic sidl;
		logic isel;
		logic go;
		logic lsb;
		logic [4:0] dw;
		logic [4:0] pl;
		logic [15:0] xorl;
		logic [15:0] xorh;
		logic [15:0] datl;
		logic [15:0] dath;
		logic [31:0] wdat;
		logic [15:0][31:0] fifo;
		logic [3:0] wptr;
		logic [3:0] rptr;
		logic [4:0] valid_word_count;
		logic [31:0] sbuf;
		logic [5:0] rem;
		logic ran;
		logic irq;
		pcrc_apb_rsp_t rsp;
	} pcrc_state_t;
endpackage

//--- verif/tb.sv
// Self-checking testbench for the programmable CRC generator.
`include "pcrc_regs.svh"
module tb
	import pcrc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic idle_mode = 1'b0;
	pcrc_apb_req_t req = '0;
	pcrc_apb_rsp_t rsp;
	logic crc_event;
	logic [31:0] rd;
	logic er;
	int failures = 0;
	int samples_checked = 0;
	int events = 0;
	always #20 pclk = ~pclk;
	always @(negedge pclk) if (crc_event === 1'b1) events++;
	pcrc_gen i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp), .idle_mode(idle_mode),
		.crc_event(crc_event));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checked %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// APB transfer: setup, access until pready, then release.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge pclk);
		req.penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (rsp.pready !== 1'b1 && n < 20);
		if (rsp.pready !== 1'b1)
		begin
			failures++;
			give_verdict();
		end
		rd = rsp.prdata;
		er = rsp.pslverr;
		req.psel <= 1'b0;
		req.penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(nm, rd, e);
	endtask
	// Polls the primary control register until the go bit drops.
	task automatic wait_go();
		int n;
		n = 0;
		do
		begin
			bus(1'b0, `PCRC_OFS_CON1, 32'h0);
			n++;
		end
		while (rd[4] !== 1'b0 && n < 60);
		chk("go_cleared", {31'h0, rd[4]}, 32'h0);
		if (rd[4] !== 1'b0)
			give_verdict();
		repeat (2) @(posedge pclk);
	endtask
	function automatic logic [31:0] crc(input logic [31:0] c, input logic [31:0] d, input int w, input int l,
		input logic [31:0] p, input logic lsb);
		logic b;
		logic [31:0] m;
		m = (l == 32) ? 32'hFFFFFFFF : (32'h1 << l) - 32'h1;
		for (int i = 0; i < w; i++)
		begin
			b = lsb ? d[i] : d[w - 1 - i];
			b = b ^ c[l - 1];
			c = c << 1;
			if (b) c = c ^ (p | 32'h1);
			c = c & m;
		end
		return c;
	endfunction
	task automatic t_reset();
		rchk("con1", `PCRC_OFS_CON1, 32'h40);
		rchk("con2", `PCRC_OFS_CON2, 32'h0);
		rchk("wdatl", `PCRC_OFS_WDATL, 32'h0);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped_err", {31'h0, er}, 32'h1);
		chk("unmapped_data", rd, 32'h0);
		$display("test reset done");
	endtask
	task automatic t_crc32();
		logic [31:0] e;
		wr(`PCRC_OFS_CON1, 32'h8000);
		wr(`PCRC_OFS_XORL, 32'hFFFF);
		rchk("xorl", `PCRC_OFS_XORL, 32'hFFFE);
		wr(`PCRC_OFS_XORL, 32'h1DB7);
		wr(`PCRC_OFS_XORH, 32'h04C1);
		rchk("xorh", `PCRC_OFS_XORH, 32'h04C1);
		wr(`PCRC_OFS_CON2, 32'h1F1F);
		rchk("con2", `PCRC_OFS_CON2, 32'h1F1F);
		wr(`PCRC_OFS_DATL, 32'h5678);
		rchk("cnt_low", `PCRC_OFS_CON1, 32'h8040);
		wr(`PCRC_OFS_DATH, 32'h1234);
		rchk("cnt_high", `PCRC_OFS_CON1, 32'h8100);
		wr(`PCRC_OFS_DATL, 32'hBEEF);
		wr(`PCRC_OFS_DATH, 32'hCAFE);
		wr(`PCRC_OFS_WDATL, 32'h0);
		wr(`PCRC_OFS_WDATH, 32'h0);
		idle_mode <= 1'b1;
		wr(`PCRC_OFS_CON1, 32'h8030);
		wr(`PCRC_OFS_DATL, 32'h9ABC);
		wr(`PCRC_OFS_DATH, 32'hDEF0);
		wait_go();
		idle_mode <= 1'b0;
		chk("events", events, 1);
		e = crc(crc(32'h0, 32'h12345678, 32, 32, 32'h04C11DB7, 1'b0), 32'hCAFEBEEF, 32, 32, 32'h04C11DB7, 1'b0);
		e = crc(e, 32'hDEF09ABC, 32, 32, 32'h04C11DB7, 1'b0);
		rchk("res_l", `PCRC_OFS_WDATL, {16'h0, e[15:0]});
		rchk("res_h", `PCRC_OFS_WDATH, {16'h0, e[31:16]});
		$display("test crc32 done");
	endtask
	task automatic t_lsb8();
		logic [31:0] e;
		wr(`PCRC_OFS_CON1, 32'h0);
		rchk("clr_res", `PCRC_OFS_WDATL, 32'h0);
		rchk("clr_dath", `PCRC_OFS_DATH, 32'h0);
		rchk("keep_xorl", `PCRC_OFS_XORL, 32'h1DB6);
		rchk("keep_con2", `PCRC_OFS_CON2, 32'h1F1F);
		wr(`PCRC_OFS_CON1, 32'h8008);
		wr(`PCRC_OFS_CON2, 32'h0707);
		wr(`PCRC_OFS_XORL, 32'h0007);
		wr(`PCRC_OFS_XORH, 32'h0);
		e = 32'h0;
		for (int i = 0; i < 17; i++)
		begin
			wr(`PCRC_OFS_DATL, i * 32'h25);
			if (i < 16) e = crc(e, i * 32'h25, 8, 8, 32'h7, 1'b1);
		end
		rchk("full", `PCRC_OFS_CON1, 32'h9088);
		@(posedge pclk);
		idle_mode <= 1'b1;
		wr(`PCRC_OFS_CON1, 32'hA018);
		repeat (20) @(posedge pclk);
		rchk("halted", `PCRC_OFS_CON1, 32'hB098);
		idle_mode <= 1'b0;
		wait_go();
		chk("events", events, 2);
		rchk("res8", `PCRC_OFS_WDATL, e);
		wr(`PCRC_OFS_CON1, 32'h8030);
		repeat (10) @(posedge pclk);
		rchk("idle_res", `PCRC_OFS_WDATL, e);
		wr(`PCRC_OFS_CON1, 32'h8020);
		repeat (5) @(posedge pclk);
		chk("sw_clear", events, 2);
		$display("test lsb8 done");
	endtask
	initial
	begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_crc32();
		t_lsb8();
		give_verdict();
	end
endmodule
